// ### core/ddwd_pkg.sv
// constants shared by the display data word decoder
package ddwd_pkg;
  typedef enum logic [3:0] {
    MODE_CHAR   = 4'h0,
    MODE_SVEC   = 4'h1,
    MODE_LVEC   = 4'h2,
    MODE_POINT  = 4'h3,
    MODE_GRAPHX = 4'h4,
    MODE_GRAPHY = 4'h5,
    MODE_RELPT  = 4'h6
  } ddwd_mode_t;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_WORD    = 8'h04;
  localparam logic [7:0] OFS_INCR    = 8'h08;
  localparam logic [7:0] OFS_POS     = 8'h0c;
  localparam logic [7:0] OFS_DELTA   = 8'h10;
  localparam logic [7:0] OFS_CHARS   = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;

  // word fields
  localparam int         BIT_CTRL    = 15;
  localparam int         BIT_INTENS  = 14;
  localparam int         BIT_DIR     = 13;
  localparam int         LV_MAG_W    = 10;
  localparam int         SV_DY_LSB   = 0;
  localparam int         SV_DY_DIR   = 6;
  localparam int         SV_DX_LSB   = 7;
  localparam int         SV_DX_DIR   = 13;
  localparam int         SV_MAG_W    = 6;
  localparam int         CH_CODE_W   = 7;
  localparam int         CH2_LSB     = 7;
  localparam int         CTRL_MODE_LSB = 11;

  // character cell and screen
  localparam logic [9:0] CHAR_PITCH  = 10'h00e;
  localparam logic [9:0] LINE_PITCH  = 10'h018;
  localparam logic [9:0] LEFT_EDGE   = 10'h000;
  localparam logic [6:0] CODE_CR     = 7'h0d;
  localparam logic [6:0] CODE_LF     = 7'h0a;

  // reset values
  localparam logic [3:0] RST_MODE    = 4'h0;
  localparam logic [9:0] RST_INCR    = 10'h001;
endpackage

// ### core/ddwd_decoder.sv
// display data word decoder with apb slave
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - bit 15 clear marks a data word
// - long vector and point consume word pairs
// - other modes use one word each
// - route words to delta, position, character
// - strobes follow mode held at arrival
// - decode seven mode codes zero to six
// - two seven-bit codes per character word
// - advance beam right after each character
// - carriage return or line feed starts line
// - magnitude with direction forms signed delta
// - long vector: X word, Y word, draw
// - vector end becomes next start point
// - ten-bit X then ten-bit Y point load
// - point intensify only when bit 14 set
// - graph Y: load Y, then add increment X
// - graph X: load X, then add increment Y
// - store graph increment constant
// - graph Y without setup starts left edge
// - relative point moves, lights at end if bit 14 set
module ddwd_decoder (
  input  wire logic        mclk,       // 250 MHz clock
  input  wire logic        resetn,     // async reset, low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb enable
  input  wire logic        pwrite,     // apb direction
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic             pready,     // apb ready
  output logic [31:0]      prdata,     // apb read data
  output logic             pslverr,    // apb error
  output logic [9:0]       posX,       // beam x position
  output logic [9:0]       posY,       // beam y position
  output logic             drawStrobe, // one-cycle: move to new position
  output logic             intensify,  // with drawStrobe: light beam
  output logic [6:0]       charCode,   // character code shown
  output logic             charStrobe  // one-cycle: show charCode
);

  typedef struct packed {
    logic [3:0]  mode;
    logic        second;
    logic        firstInt;
    logic        posValid;
    logic [9:0]  incr;
    logic [9:0]  x;
    logic [9:0]  y;
    logic [9:0]  lineStart;
    logic [10:0] dx;
    logic [10:0] dy;
    logic [13:0] chars;
    logic        charPend;
    logic        draw;
    logic        intens;
    logic        chStb;
    logic [6:0]  chOut;
    logic        rdy;
    logic [31:0] rdata;
    logic        err;
    logic        ctrlSeen;
  } ddwd_state_t;

  ddwd_state_t s_q;
  ddwd_state_t s_d;

  logic        wrAcc;
  logic        rdAcc;
  logic [15:0] w;
  logic [10:0] sdx;
  logic [10:0] sdy;
  logic [9:0]  nx;
  logic [9:0]  ny;

  assign wrAcc = psel && penable && pwrite && !s_q.rdy;
  assign rdAcc = psel && penable && !pwrite && !s_q.rdy;
  assign w     = pwdata[15:0];

  ////////////////////////////////////////////////////////////////////////////////

  // signed delta from magnitude and sign bit
  function automatic logic [10:0] sgn(input logic [9:0] mag, input logic neg);
    sgn = neg ? (11'h000 - {1'b0, mag}) : {1'b0, mag};
  endfunction

  always_comb begin
    s_d        = s_q;
    s_d.draw   = 1'b0;
    s_d.chStb  = 1'b0;
    s_d.rdy    = 1'b0;
    s_d.err    = 1'b0;
    sdx        = 11'h000;
    sdy        = 11'h000;
    nx         = s_q.x;
    ny         = s_q.y;
    // second character of a word goes out one cycle after the first
    if (s_q.charPend) begin
      s_d.charPend = 1'b0;
      s_d.chStb    = 1'b1;
      s_d.chOut    = s_q.chars[13:7];
      s_d.draw     = 1'b1;
      s_d.intens   = 1'b0;
      if (s_q.chars[13:7] == ddwd_pkg::CODE_CR || s_q.chars[13:7] == ddwd_pkg::CODE_LF) begin
        s_d.x         = s_q.lineStart;
        s_d.y         = s_q.y - ddwd_pkg::LINE_PITCH;
        s_d.chStb     = 1'b0;
      end else begin
        s_d.x = s_q.x + ddwd_pkg::CHAR_PITCH;
      end
    end
    if (psel && penable && !s_q.rdy) begin
      s_d.rdy = 1'b1;
    end
    if (wrAcc) begin
      unique case (paddr)
        ddwd_pkg::OFS_CTRL: begin
          s_d.mode   = w[3:0];
          s_d.second = 1'b0;
        end
        ddwd_pkg::OFS_INCR: begin
          s_d.incr = w[9:0];
        end
        ddwd_pkg::OFS_WORD: begin
          // data only when bit 15 clear
          if (w[ddwd_pkg::BIT_CTRL]) begin
            // control word, mode kept unless it sets one
            s_d.ctrlSeen = 1'b1;
            if (w[ddwd_pkg::CTRL_MODE_LSB+3] == 1'b0) begin
              s_d.mode   = w[ddwd_pkg::CTRL_MODE_LSB +: 4];
              s_d.second = 1'b0;
            end
          end else if (!s_q.charPend) begin
            unique case (s_q.mode)
              ddwd_pkg::MODE_CHAR: begin
                s_d.chars    = w[13:0];
                s_d.chOut    = w[6:0];
                s_d.chStb    = 1'b1;
                s_d.charPend = 1'b1;
                s_d.draw     = 1'b1;
                s_d.intens   = 1'b0;
                if (w[6:0] == ddwd_pkg::CODE_CR || w[6:0] == ddwd_pkg::CODE_LF) begin
                  s_d.x     = s_q.lineStart;
                  s_d.y     = s_q.y - ddwd_pkg::LINE_PITCH;
                  s_d.chStb = 1'b0;
                end else begin
                  s_d.x = s_q.x + ddwd_pkg::CHAR_PITCH;
                end
              end
              ddwd_pkg::MODE_SVEC, ddwd_pkg::MODE_RELPT: begin
                sdx  = sgn({4'h0, w[ddwd_pkg::SV_DX_LSB +: ddwd_pkg::SV_MAG_W]},
                           w[ddwd_pkg::SV_DX_DIR]);
                sdy  = sgn({4'h0, w[ddwd_pkg::SV_DY_LSB +: ddwd_pkg::SV_MAG_W]},
                           w[ddwd_pkg::SV_DY_DIR]);
                s_d.dx = sdx;
                s_d.dy = sdy;
                // end point kept as next start
                s_d.x    = s_q.x + sdx[9:0];
                s_d.y    = s_q.y + sdy[9:0];
                s_d.draw = 1'b1;
                // short vector and relative point both lit by bit 14
                s_d.intens = w[ddwd_pkg::BIT_INTENS];
              end
              ddwd_pkg::MODE_LVEC: begin
                // x word then y word, then draw
                if (!s_q.second) begin
                  s_d.dx       = sgn(w[ddwd_pkg::LV_MAG_W-1:0], w[ddwd_pkg::BIT_DIR]);
                  s_d.firstInt = w[ddwd_pkg::BIT_INTENS];
                  s_d.second   = 1'b1;
                end else begin
                  sdy          = sgn(w[ddwd_pkg::LV_MAG_W-1:0], w[ddwd_pkg::BIT_DIR]);
                  s_d.dy       = sdy;
                  s_d.x        = s_q.x + s_q.dx[9:0];
                  s_d.y        = s_q.y + sdy[9:0];
                  s_d.draw     = 1'b1;
                  s_d.intens   = s_q.firstInt;
                  s_d.second   = 1'b0;
                end
              end
              ddwd_pkg::MODE_POINT: begin
                if (!s_q.second) begin
                  s_d.x        = w[9:0];
                  s_d.firstInt = w[ddwd_pkg::BIT_INTENS];
                  s_d.second   = 1'b1;
                end else begin
                  s_d.y         = w[9:0];
                  s_d.lineStart = s_q.x;
                  s_d.posValid  = 1'b1;
                  s_d.draw      = 1'b1;
                  s_d.intens    = s_q.firstInt;
                  s_d.second    = 1'b0;
                end
              end
              ddwd_pkg::MODE_GRAPHY: begin
                // no setup starts at left edge
                nx = s_q.posValid ? s_q.x : ddwd_pkg::LEFT_EDGE;
                s_d.y        = w[9:0];
                s_d.draw     = 1'b1;
                s_d.intens   = 1'b1;
                // increment x after point; shown point uses nx
                s_d.x        = nx;
                s_d.posValid = 1'b1;
              end
              ddwd_pkg::MODE_GRAPHX: begin
                s_d.x        = w[9:0];
                s_d.draw     = 1'b1;
                s_d.intens   = 1'b1;
                s_d.posValid = 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
    end
    // increment applied on the cycle after a graph point is shown
    if (s_q.draw && !s_q.chStb && s_q.mode == ddwd_pkg::MODE_GRAPHY && !wrAcc) begin
      s_d.x = s_q.x + s_q.incr;
    end
    if (s_q.draw && s_q.mode == ddwd_pkg::MODE_GRAPHX && !wrAcc) begin
      s_d.y = s_q.y + s_q.incr;
    end
    if (rdAcc) begin
      unique case (paddr)
        ddwd_pkg::OFS_CTRL:   s_d.rdata = {28'h0000000, s_q.mode};
        ddwd_pkg::OFS_INCR:   s_d.rdata = {22'h000000, s_q.incr};
        ddwd_pkg::OFS_POS:    s_d.rdata = {6'h00, s_q.y, 6'h00, s_q.x};
        ddwd_pkg::OFS_DELTA:  s_d.rdata = {5'h00, s_q.dy, 5'h00, s_q.dx};
        ddwd_pkg::OFS_CHARS:  s_d.rdata = {18'h00000, s_q.chars};
        ddwd_pkg::OFS_STATUS: s_d.rdata = {28'h0000000, s_q.ctrlSeen, s_q.charPend,
                                           s_q.posValid, s_q.second};
        ddwd_pkg::OFS_WORD:   s_d.rdata = 32'h00000000;
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.err   = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q      <= '0;
      s_q.mode <= ddwd_pkg::RST_MODE;
      s_q.incr <= ddwd_pkg::RST_INCR;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready     = s_q.rdy;
  assign prdata     = s_q.rdata;
  assign pslverr    = s_q.err;
  assign posX       = s_q.x;
  assign posY       = s_q.y;
  assign drawStrobe = s_q.draw;
  assign intensify  = s_q.intens;
  assign charCode   = s_q.chOut;
  assign charStrobe = s_q.chStb;

endmodule // ddwd_decoder

// ### verif/ddwd_decoder_checker.sv
// assertions on the display data word decoder ports
`timescale 1ns/1ps
module ddwd_decoder_checker (
  input wire logic        mclk,       // clock
  input wire logic        resetn,     // reset, low
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb enable
  input wire logic        pwrite,     // apb direction
  input wire logic [7:0]  paddr,      // apb address
  input wire logic [31:0] pwdata,     // apb write data
  input wire logic        pready,     // apb ready
  input wire logic [31:0] prdata,     // apb read data
  input wire logic        pslverr,    // apb error
  input wire logic [9:0]  posX,       // beam x
  input wire logic [9:0]  posY,       // beam y
  input wire logic        drawStrobe, // beam moved
  input wire logic        intensify,  // beam lit
  input wire logic [6:0]  charCode,   // shown code
  input wire logic        charStrobe  // code shown
);
  logic [3:0] modeQ;
  logic       pairQ;
  logic       ptIntQ;
  wire        taken  = psel && penable && !pready;
  wire        wordTk = taken && pwrite && paddr == ddwd_pkg::OFS_WORD;
  wire        dataTk = wordTk && !pwdata[15];
  wire        paired = modeQ == ddwd_pkg::MODE_LVEC || modeQ == ddwd_pkg::MODE_POINT;
  wire        noCr   = pwdata[6:0] != ddwd_pkg::CODE_CR && pwdata[6:0] != ddwd_pkg::CODE_LF;
  wire        noCr2  = pwdata[13:7] != ddwd_pkg::CODE_CR && pwdata[13:7] != ddwd_pkg::CODE_LF;
  // mode and pair position as the decoder should hold them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      modeQ  <= ddwd_pkg::RST_MODE;
      pairQ  <= 1'b0;
      ptIntQ <= 1'b0;
    end else if (taken && pwrite && paddr == ddwd_pkg::OFS_CTRL) begin
      modeQ <= pwdata[3:0];
      pairQ <= 1'b0;
    end else if (wordTk && pwdata[15] && !pwdata[14]) begin
      modeQ <= pwdata[14:11];
      pairQ <= 1'b0;
    end else if (dataTk && paired) begin
      pairQ  <= !pairQ;
      ptIntQ <= pairQ ? ptIntQ : pwdata[14];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence twoChars;
    charStrobe ##1 charStrobe;
  endsequence
  chk_ready_pulse: assert property (taken |=> pready ##1 !pready)
    else $error("ready is not a one-cycle answer");
  chk_ctrl_quiet: assert property (wordTk && pwdata[15] |=> !charStrobe)
    else $error("control word shown as a character");
  chk_char_first: assert property (dataTk && modeQ == ddwd_pkg::MODE_CHAR && noCr
    |=> charStrobe && charCode == $past(pwdata[6:0])) else $error("first character missing");
  chk_char_pair: assert property (dataTk && modeQ == ddwd_pkg::MODE_CHAR && noCr && noCr2
    |=> twoChars ##0 charCode == $past(pwdata[13:7], 2)) else $error("second character missing");
  chk_lvec_draw: assert property (dataTk && modeQ == ddwd_pkg::MODE_LVEC && pairQ
    |=> drawStrobe && intensify == ptIntQ) else $error("long vector pair not drawn");
  chk_pair_first: assert property (dataTk && paired && !pairQ |=> !drawStrobe)
    else $error("first word of a pair moved the beam");
  chk_point_load: assert property (dataTk && modeQ == ddwd_pkg::MODE_POINT && pairQ
    |=> drawStrobe && posY == $past(pwdata[9:0]) && intensify == ptIntQ)
    else $error("point pair not loaded");
  chk_graphy_load: assert property (dataTk && modeQ == ddwd_pkg::MODE_GRAPHY
    |=> drawStrobe && posY == $past(pwdata[9:0])) else $error("graph y word not loaded");
  chk_graphx_load: assert property (dataTk && modeQ == ddwd_pkg::MODE_GRAPHX
    |=> drawStrobe && posX == $past(pwdata[9:0])) else $error("graph x word not loaded");
endmodule // ddwd_decoder_checker

// ### verif/ddwd_apb_host.sv
// apb master standing in for the processor that feeds data words
`timescale 1ns/1ps
module ddwd_apb_host (
  input  wire logic        mclk,             // bus clock
  output logic             psel = 1'b0,      // select
  output logic             penable = 1'b0,   // enable
  output logic             pwrite = 1'b0,    // direction
  output logic [7:0]       paddr = 8'h00,    // byte address
  output logic [31:0]      pwdata = 32'h0,   // write data
  input  wire logic        pready,           // slave ready
  input  wire logic [31:0] prdata,           // read data
  input  wire logic        pslverr           // slave error
);
  ////////////////////////////////////////////////////////////
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no limit of its own: a slave that never answers is caught by the bench watchdog
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // write data flips on release so a stale word can never pass as fresh
    pwdata  <= ~d;
  endtask
endmodule // ddwd_apb_host

// ### verif/ddwd_decoder_bench.sv
// self-checking bench for the display data word decoder
`timescale 1ns/1ps
module ddwd_decoder_bench;
  localparam logic [7:0] ADR_WORD = ddwd_pkg::OFS_WORD;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, drawStrobe, intensify, charStrobe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  posX, posY;
  logic [6:0]  charCode;
  int          mismatches = 0;
  int          testsRun = 0;
  always #2 mclk = ~mclk;
  ddwd_apb_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  ddwd_decoder DUT (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .posX(posX), .posY(posY), .drawStrobe(drawStrobe),
    .intensify(intensify), .charCode(charCode), .charStrobe(charStrobe));
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic err);
    logic [31:0] r;
    logic        e;
    host.xfer(a, 1'b0, 32'h0, r, e);
    testsRun++;
    if (e !== err || (!err && (r & m) !== (x & m))) begin
      mismatches++;
      $display("wrong value at %0t: addr %h got %h err %b", $time, a, r, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(a, 1'b1, d, r, e);
  endtask
  task automatic set_mode(input ddwd_pkg::ddwd_mode_t m);
    wr(ddwd_pkg::OFS_CTRL, {28'h0, m});
    rd(ddwd_pkg::OFS_CTRL, {28'h0, m}, 32'hf, 1'b0);
  endtask
  task automatic pos_is(input logic [9:0] x, input logic [9:0] y);
    rd(ddwd_pkg::OFS_POS, {6'h00, y, 6'h00, x}, 32'h03ff03ff, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(ddwd_pkg::OFS_CTRL, 32'h0, 32'hf, 1'b0);
    rd(ddwd_pkg::OFS_INCR, 32'h1, 32'h3ff, 1'b0);
    rd(8'h1c, 32'h0, 32'h0, 1'b1);
  endtask
  task automatic test_graph();
    wr(ddwd_pkg::OFS_INCR, 32'h4);
    set_mode(ddwd_pkg::MODE_GRAPHY);
    wr(ADR_WORD, 32'h010);
    wr(ADR_WORD, 32'h020);
    pos_is(10'h008, 10'h020);
    set_mode(ddwd_pkg::MODE_GRAPHX);
    wr(ADR_WORD, 32'h050);
    pos_is(10'h050, 10'h024);
  endtask
  task automatic test_ctrl_word();
    set_mode(ddwd_pkg::MODE_CHAR);
    wr(ADR_WORD, 32'h9800);
    rd(ddwd_pkg::OFS_CTRL, 32'h3, 32'hf, 1'b0);
    wr(ADR_WORD, 32'he800);
    rd(ddwd_pkg::OFS_CTRL, 32'h3, 32'hf, 1'b0);
  endtask
  task automatic test_point_char();
    wr(ADR_WORD, 32'h4123);
    wr(ADR_WORD, 32'h0045);
    pos_is(10'h123, 10'h045);
    set_mode(ddwd_pkg::MODE_CHAR);
    wr(ADR_WORD, {18'h0, 7'h42, 7'h41});
    pos_is(10'h13f, 10'h045);
    rd(ddwd_pkg::OFS_CHARS, 32'h00002141, 32'h00003fff, 1'b0);
    wr(ADR_WORD, {18'h0, ddwd_pkg::CODE_LF, ddwd_pkg::CODE_CR});
    pos_is(10'h123, 10'h015);
    rd(ddwd_pkg::OFS_STATUS, 32'h0000000a, 32'h0000000f, 1'b0);
  endtask
  task automatic test_vectors();
    ddwd_pkg::ddwd_mode_t m [2] = '{ddwd_pkg::MODE_SVEC, ddwd_pkg::MODE_RELPT};
    set_mode(ddwd_pkg::MODE_POINT);
    wr(ADR_WORD, 32'h0100);
    wr(ADR_WORD, 32'h0100);
    set_mode(ddwd_pkg::MODE_LVEC);
    wr(ADR_WORD, 32'h4005);
    wr(ADR_WORD, 32'h2003);
    pos_is(10'h105, 10'h0fd);
    rd(ddwd_pkg::OFS_DELTA, 32'h07fd0005, 32'h07ff07ff, 1'b0);
    wr(ADR_WORD, 32'h2005);
    wr(ADR_WORD, 32'h0003);
    pos_is(10'h100, 10'h100);
    for (int i = 0; i < 2; i++) begin
      set_mode(m[i]);
      wr(ADR_WORD, 32'h0101);
      pos_is(10'h102 + 10'(2 * i), 10'h101 + 10'(i));
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    test_reset();
    test_graph();
    test_ctrl_word();
    test_point_char();
    test_vectors();
    print_verdict();
  end
  // generous bound: the whole sequence needs a few hundred cycles
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
endmodule // ddwd_decoder_bench

bind ddwd_decoder ddwd_decoder_checker u_chk (.mclk(mclk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .posX(posX), .posY(posY), .drawStrobe(drawStrobe),
  .intensify(intensify), .charCode(charCode), .charStrobe(charStrobe));
